// ==== core/cca_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH
// byte offsets on the register port
`define A_CURR_HI 8'h20
`define A_CURR_LO 8'h21
`define A_ACR_HI 8'h22
`define A_ACR_LO 8'h23
`define A_OFS_BIAS 8'h24
`define A_CTRL 8'h25
`define A_ACC_BIAS 8'h26
`define A_CYCLES 8'h27
`define A_GAIN_HI 8'h28
`define A_GAIN_LO 8'h29
`define A_TEMPCO 8'h2a
`define A_FGAIN_HI 8'hb0
`define A_FGAIN_LO 8'hb1
// control register field
`define CTRL_DBLANK 0
// reset values
`define OFS_BIAS_RST 8'h00
// conversion schedule: offset slot of the modulo-1024 count
`define OFS_SLOT 10'h3ff
// blanking limits in current lsbs (100uV and 25uV)
`define CHG_BLANK 16'h0040
`define DIS_BLANK 16'h0010
// hidden fraction bits below the visible accumulator lsb
`define ACC_FRAC 12
`define CYC_MAX 8'hff
// tempco reference temperature in half degrees (25 C)
`define TC_REF_HALF 9'h032
// host write window for the accumulator pair
`define ACR_WIN_MS 3500
`define MCLK_KHZ 20000
`endif

// ==== core/cca_pkg.sv ====
// types shared by the current accumulation block
package cca_pkg;
    // host register port request
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } reg_req_t;
    // one conversion result from the adc
    typedef struct packed {
        logic valid;
        logic signed [15:0] raw;
    } adc_t;
    // image restored from eeprom at power-up
    typedef struct packed {
        logic [10:0] gain;
        logic [15:0] fgain;
        logic [7:0] tempco;
        logic signed [7:0] acc_bias;
        logic [15:0] charge_accumulator;
    } ee_image_t;
    // conversion phase
    typedef enum logic {PH_NORMAL, PH_FORCED} phase_t;
    // whole state of the top module
    typedef struct packed {
        phase_t phase;
        logic [9:0] conv_cnt;
        logic ofs_next;
        logic signed [15:0] offset;
        logic signed [15:0] cur;
        logic [27:0] acc;
        logic [7:0] hi_buf;
        logic hi_pend;
        logic [26:0] win_cnt;
        logic signed [7:0] ofs_bias;
        logic dblank;
        logic signed [7:0] acc_bias;
        logic [10:0] gain;
        logic [15:0] fgain;
        logic [7:0] tempco;
        logic signed [18:0] comp;
        logic signed [8:0] last_half;
        logic [7:0] cycles;
        logic [7:0] rdata;
        logic backup;
        logic [15:0] backup_val;
        logic [7:0] bk_cnt;
    } state_t;
endpackage

// ==== core/current_conditioner.sv ====
// offset removal, gain trim, tempco, offset bias and clamping of one sample
module current_conditioner
    import cca_pkg::*;
(
    input wire logic signed [15:0] raw,
    input wire logic signed [15:0] offset,
    input wire logic [10:0] gain,
    input wire logic signed [18:0] comp,
    input wire logic signed [7:0] bias,
    output logic signed [15:0] cur
);
    logic signed [16:0] diff; // offset-corrected sample
    logic signed [28:0] g_full; // gain product
    logic signed [18:0] g; // gain applied, 2^-10 steps
    logic signed [37:0] t_full; // tempco product
    logic signed [18:0] t; // tempco share to remove
    logic signed [20:0] sum; // before clamping

    // datapath; one conversion every few seconds, so no pipelining
    always_comb
    begin
        diff = {raw[15], raw} - {offset[15], offset};
        g_full = diff * $signed({1'b0, gain});
        g = g_full[28:10];
        t_full = g * comp;
        t = t_full[34:16];
        sum = {{2{g[18]}}, g} - {{2{t[18]}}, t} + {{13{bias[7]}}, bias};
        // clamp to the register range
        if (sum > 21'sh007fff)
        begin
            cur = 16'h7fff;
        end
        else if (sum < -21'sh008000)
        begin
            cur = 16'h8000;
        end
        else
        begin
            cur = sum[15:0];
        end
    end
endmodule

// ==== core/acc_saturator.sv ====
// saturating add into the charge accumulator with hidden fraction
module acc_saturator
    import cca_pkg::*;
(
    input wire logic [27:0] acc,
    input wire logic signed [16:0] delta,
    output logic [27:0] acc_next
);
    logic signed [29:0] s; // wide sum, never wraps

    // clamp at both ends instead of wrapping
    always_comb
    begin
        s = $signed({2'b00, acc}) + {{13{delta[16]}}, delta};
        if (s < 30'sh0)
        begin
            acc_next = 28'h0;
        end
        else if (s[28])
        begin
            acc_next = 28'hfffffff;
        end
        else
        begin
            acc_next = s[27:0];
        end
    end
endmodule

// ==== core/coulomb_current_accumulator.sv ====
// current post-processing and coulomb counting, top module
`include "cca_regs.svh"

module coulomb_current_accumulator
    import cca_pkg::*;
#(
    parameter int unsigned ACR_WIN_CYC = `ACR_WIN_MS * `MCLK_KHZ,
    parameter logic [7:0] BACKUP_CONVS = 8'h10
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_t req,
    output logic [7:0] rd_data,
    input wire adc_t adc,
    output logic meas_offset,
    input wire logic signed [10:0] temp,
    input wire logic ee_load,
    input wire ee_image_t ee_img,
    output logic backup_stb,
    output logic [15:0] backup_acr,
    input wire logic cycle_tick,
    input wire logic block1_locked
);
    state_t st_q; // registered state
    state_t st_d; // next state
    logic signed [15:0] cur_new; // conditioned sample
    logic signed [15:0] acc_src; // value used for accumulation
    logic blank; // sample masked from accumulation
    logic signed [16:0] delta; // sample plus bias
    logic [27:0] acc_step; // saturated accumulator
    logic signed [8:0] half; // temperature in half degrees
    logic signed [18:0] tc_prod; // compensation for this temperature
    logic acr_lo_wr; // completing accumulator write
    logic wr_hit; // host write strobe

    // blanking decode, shared with the checks below
    function automatic logic is_blanked(input logic signed [15:0] v, input logic en);
        logic chg;
        logic dis;
        chg = (v > 16'sh0) && (v < $signed(`CHG_BLANK));
        dis = en && (v < 16'sh0) && (v > -$signed(`DIS_BLANK));
        return chg || dis;
    endfunction

    // sample conditioning
    current_conditioner u_cond (
        .raw(adc.raw),
        .offset(st_q.offset),
        .gain(st_q.gain),
        .comp(st_q.comp),
        .bias(st_q.ofs_bias),
        .cur(cur_new)
    );

    // during an offset slot the last real current stands in
    assign acc_src = st_q.ofs_next ? st_q.cur : cur_new;
    assign blank = is_blanked(acc_src, st_q.dblank);
    // bias goes in even when the sample is blanked
    assign delta = (blank ? 17'sh0 : {acc_src[15], acc_src})
        + {{9{st_q.acc_bias[7]}}, st_q.acc_bias};

    // saturating accumulation
    acc_saturator u_acc (
        .acc(st_q.acc),
        .delta(delta),
        .acc_next(acc_step)
    );

    // half-degree temperature and the compensation it implies
    assign half = temp[10:2];
    // reference kept signed so readings below it give a negative share
    assign tc_prod = (half - $signed(`TC_REF_HALF)) * $signed({1'b0, st_q.tempco});
    assign wr_hit = req.wr;
    assign acr_lo_wr = wr_hit && req.addr == `A_ACR_LO && st_q.hi_pend;

    // next-state logic
    always_comb
    begin
        st_d = st_q;
        st_d.backup = 1'b0;
        // accumulator write window
        if (st_q.hi_pend)
        begin
            if (st_q.win_cnt == 27'h0)
            begin
                st_d.hi_pend = 1'b0;
            end
            else
            begin
                st_d.win_cnt = st_q.win_cnt - 27'h1;
            end
        end
        // compensation refreshed only on a new half degree
        if (half != st_q.last_half)
        begin
            st_d.last_half = half;
            st_d.comp = tc_prod;
        end
        // discharge cycle odometer, one step per cycle_tick
        if (cycle_tick && st_q.cycles != `CYC_MAX)
        begin
            st_d.cycles = st_q.cycles + 8'h01;
        end
        // conversion result handling
        if (adc.valid)
        begin
            st_d.conv_cnt = st_q.conv_cnt + 10'h001;
            st_d.ofs_next = (st_d.conv_cnt == `OFS_SLOT);
            case (st_q.phase)
                PH_NORMAL:
                begin
                    if (st_q.ofs_next)
                    begin
                        // offset slot: keep current, reuse it
                        st_d.offset = adc.raw;
                    end
                    else
                    begin
                        st_d.cur = cur_new;
                    end
                    st_d.acc = acc_step;
                    // periodic backup of the visible count
                    if (st_q.bk_cnt == BACKUP_CONVS - 8'h01)
                    begin
                        st_d.bk_cnt = 8'h00;
                        st_d.backup = 1'b1;
                        st_d.backup_val = acc_step[27:`ACC_FRAC];
                    end
                    else
                    begin
                        st_d.bk_cnt = st_q.bk_cnt + 8'h01;
                    end
                end
                PH_FORCED:
                begin
                    // forced offset: no measurement, no accumulation
                    st_d.offset = adc.raw;
                    st_d.phase = PH_NORMAL;
                end
                default:
                begin
                    st_d.phase = PH_NORMAL;
                end
            endcase
        end
        // host writes take priority over the update above
        if (wr_hit)
        begin
            case (req.addr)
                `A_ACR_HI:
                begin
                    st_d.hi_buf = req.wdata;
                    st_d.hi_pend = 1'b1;
                    st_d.win_cnt = 27'(ACR_WIN_CYC - 1);
                end
                `A_ACR_LO:
                begin
                    // low byte without a fresh high byte is ignored
                    if (st_q.hi_pend)
                    begin
                        st_d.acc = {st_q.hi_buf, req.wdata, 12'h000};
                        st_d.hi_pend = 1'b0;
                        st_d.phase = PH_FORCED;
                        st_d.conv_cnt = `OFS_SLOT;
                        st_d.ofs_next = 1'b1;
                    end
                end
                `A_OFS_BIAS:
                begin
                    st_d.ofs_bias = req.wdata;
                end
                `A_CTRL:
                begin
                    st_d.dblank = req.wdata[`CTRL_DBLANK];
                end
                `A_ACC_BIAS:
                begin
                    st_d.acc_bias = req.wdata;
                end
                `A_CYCLES:
                begin
                    if (!block1_locked)
                    begin
                        st_d.cycles = req.wdata;
                    end
                end
                `A_GAIN_HI:
                begin
                    st_d.gain[10:8] = req.wdata[2:0];
                end
                `A_GAIN_LO:
                begin
                    st_d.gain[7:0] = req.wdata;
                end
                `A_TEMPCO:
                begin
                    st_d.tempco = req.wdata;
                end
                default:
                begin
                    // read-only or unmapped: no effect
                    st_d.tempco = st_q.tempco;
                end
            endcase
        end
        // power-up restore from eeprom
        if (ee_load)
        begin
            st_d.gain = ee_img.gain;
            st_d.fgain = ee_img.fgain;
            st_d.tempco = ee_img.tempco;
            st_d.acc_bias = ee_img.acc_bias;
            st_d.acc = {ee_img.charge_accumulator, 12'h000};
        end
        // read data, registered one cycle after the address
        case (req.addr)
            `A_CURR_HI: st_d.rdata = st_q.cur[15:8];
            `A_CURR_LO: st_d.rdata = st_q.cur[7:0];
            `A_ACR_HI: st_d.rdata = st_q.acc[27:20];
            `A_ACR_LO: st_d.rdata = st_q.acc[19:12];
            `A_OFS_BIAS: st_d.rdata = st_q.ofs_bias;
            `A_CTRL: st_d.rdata = {7'h00, st_q.dblank};
            `A_ACC_BIAS: st_d.rdata = st_q.acc_bias;
            `A_CYCLES: st_d.rdata = st_q.cycles;
            `A_GAIN_HI: st_d.rdata = {5'h00, st_q.gain[10:8]};
            `A_GAIN_LO: st_d.rdata = st_q.gain[7:0];
            `A_TEMPCO: st_d.rdata = st_q.tempco;
            `A_FGAIN_HI: st_d.rdata = st_q.fgain[15:8];
            `A_FGAIN_LO: st_d.rdata = st_q.fgain[7:0];
            default: st_d.rdata = 8'h00;
        endcase
    end

    // state register; offset bias is volatile and starts at zero
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.ofs_bias <= `OFS_BIAS_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flops
    assign rd_data = st_q.rdata;
    assign meas_offset = st_q.ofs_next;
    assign backup_stb = st_q.backup;
    assign backup_acr = st_q.backup_val;

    // offset schedule, slot handling and offset bias reset
    a_offset_slot: assert property (@(posedge mclk) disable iff (rst)
        (adc.valid && st_q.conv_cnt == 10'h3fe && !wr_hit) |=> meas_offset)
        else $error("offset slot not scheduled");
    a_cur_kept: assert property (@(posedge mclk) disable iff (rst)
        (adc.valid && st_q.ofs_next) |=> st_q.cur == $past(st_q.cur))
        else $error("current changed in offset slot");
    a_bias_reset: assert property (@(posedge mclk)
        $fell(rst) |-> st_q.ofs_bias == 8'sh00)
        else $error("offset bias not zero after reset");
    // blanking windows on the accumulated sample
    a_chg_blank: assert property (@(posedge mclk) disable iff (rst)
        (acc_src > 16'sh0 && acc_src < 16'sh0040) |-> blank)
        else $error("small charge not blanked");
    a_dis_blank: assert property (@(posedge mclk) disable iff (rst)
        (acc_src < 16'sh0 && acc_src > -16'sh0010) |-> blank == st_q.dblank)
        else $error("discharge blanking wrong");
    // saturation and host writes of the accumulator
    a_acc_sat: assert property (@(posedge mclk) disable iff (rst)
        (st_q.acc == 28'hfffffff && !delta[16]) |-> acc_step == 28'hfffffff)
        else $error("accumulator wrapped");
    a_acr_write: assert property (@(posedge mclk) disable iff (rst)
        (acr_lo_wr && !ee_load) |=> st_q.acc[11:0] == 12'h0 && st_q.phase == PH_FORCED)
        else $error("accumulator write wrong");
    a_forced_skip: assert property (@(posedge mclk) disable iff (rst)
        (st_q.phase == PH_FORCED && adc.valid && !wr_hit && !ee_load)
        |=> st_q.acc == $past(st_q.acc) && st_q.conv_cnt == 10'h000)
        else $error("forced offset accumulated");
    // discharge cycle odometer
    a_cyc_clamp: assert property (@(posedge mclk) disable iff (rst)
        (st_q.cycles == 8'hff && !wr_hit) |=> st_q.cycles == 8'hff)
        else $error("cycle counter rolled over");
    a_cyc_lock: assert property (@(posedge mclk) disable iff (rst)
        (block1_locked && !cycle_tick) |=> $stable(st_q.cycles))
        else $error("locked cycle counter changed");
    // compensation moves only on a half-degree crossing
    a_tc_hold: assert property (@(posedge mclk) disable iff (rst)
        (half == st_q.last_half) |=> $stable(st_q.comp))
        else $error("tempco updated without crossing");

    // an unfinished accumulator write lapses when its window runs out
    a_win_expire: assert property (@(posedge mclk) disable iff (rst)
        (st_q.hi_pend && st_q.win_cnt == 27'h0 && !wr_hit) |=> !st_q.hi_pend)
        else $error("accumulator write window not closed");
    // the factory copy changes only through the power-up restore
    a_fgain_ro: assert property (@(posedge mclk) disable iff (rst)
        !ee_load |=> $stable(st_q.fgain))
        else $error("factory gain copy changed");
    // a completed accumulator write forces the next conversion to offset
    a_forced_flag: assert property (@(posedge mclk) disable iff (rst)
        acr_lo_wr |=> meas_offset && st_q.conv_cnt == 10'h3ff)
        else $error("accumulator write did not force offset");
    // the current register moves only with a conversion result
    a_cur_hold: assert property (@(posedge mclk) disable iff (rst)
        !adc.valid |=> $stable(st_q.cur))
        else $error("current changed without a conversion");
    // an offset slot result becomes the new correction
    a_ofs_store: assert property (@(posedge mclk) disable iff (rst)
        (adc.valid && st_q.ofs_next) |=> st_q.offset == $past(adc.raw))
        else $error("offset result not stored");
    // charges at or above the limit always count
    a_chg_count: assert property (@(posedge mclk) disable iff (rst)
        (acc_src >= 16'sh0040) |-> !blank)
        else $error("charge at limit blanked");
    // each tick below the ceiling adds exactly one step
    a_cyc_step: assert property (@(posedge mclk) disable iff (rst)
        (cycle_tick && st_q.cycles != 8'hff && !wr_hit)
        |=> st_q.cycles == $past(st_q.cycles) + 8'h01)
        else $error("cycle counter step wrong");
endmodule

// ==== testbench/adc_model.sv ====
// behavioural current-sense converter facing the accumulation block
module adc_model
    import cca_pkg::*;
(
    input wire logic mclk,
    input wire logic go,
    input wire logic signed [15:0] sense,
    input wire logic signed [15:0] ofs_val,
    input wire logic meas_offset,
    output adc_t adc
);
    timeunit 1ns;
    timeprecision 1ns;
    // one result per request; between results raw shows the inverse of the sense value
    always @(negedge mclk)
    begin
        adc.valid <= go;
        // offset slot measures the converter's own input offset
        adc.raw <= go ? (meas_offset ? ofs_val : sense) : ~sense;
    end
endmodule

// ==== testbench/coulomb_current_accumulator_tb_top.sv ====
// self-checking bench for the current accumulation block
module coulomb_current_accumulator_tb_top
    import cca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, ee_load, cycle_tick, block1_locked, meas_offset, backup_stb, go;
    reg_req_t req; // host register request
    logic [7:0] rd_data;
    adc_t adc;
    logic signed [10:0] temp; // 0.125 C steps
    ee_image_t ee_img; // power-up image
    logic [15:0] backup_acr;
    logic [15:0] lbk; // last value handed to the backup
    logic signed [15:0] sense, ofs_val; // model stimulus
    int errors, n_checks, cyc, nbk;
    // short host window and frequent backups keep the run small
    coulomb_current_accumulator #(.ACR_WIN_CYC(20), .BACKUP_CONVS(8'h04)) dut (.mclk(mclk),
        .rst(rst), .req(req), .rd_data(rd_data), .adc(adc), .meas_offset(meas_offset),
        .temp(temp), .ee_load(ee_load), .ee_img(ee_img), .backup_stb(backup_stb),
        .backup_acr(backup_acr), .cycle_tick(cycle_tick), .block1_locked(block1_locked));
    adc_model adc_i (.mclk(mclk), .go(go), .sense(sense), .ofs_val(ofs_val),
        .meas_offset(meas_offset), .adc(adc));
    // 50 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // hang guard and backup capture, sampled away from the launching edge
    always @(negedge mclk)
    begin
        cyc++;
        if (backup_stb === 1'b1)
        begin
            nbk++;
            lbk = backup_acr;
        end
        if (cyc == 20000)
        begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one byte write; strobe lasts one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req <= {a, 1'b1, d};
        @(negedge mclk);
        req.wr <= 1'b0;
    endtask
    // read pair hi then lo; data settles a cycle after the address
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        @(negedge mclk);
        req.addr <= a;
        repeat (2) @(negedge mclk);
        v[15:8] = rd_data;
        req.addr <= a + 8'h01;
        repeat (2) @(negedge mclk);
        v[7:0] = rd_data;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd16(a, v);
        chk(v, exp);
    endtask
    // one conversion through the model
    task automatic conv(input logic [15:0] s);
        @(negedge mclk);
        go <= 1'b1;
        sense <= s;
        @(negedge mclk);
        go <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    // accumulator write, high byte first, then the forced offset conversion
    task automatic setacc(input logic [15:0] v);
        wr(8'h22, v[15:8]);
        wr(8'h23, v[7:0]);
        conv(16'h0000);
    endtask
    task automatic t_power_up();
        logic [15:0] v;
        rd16(8'h24, v);
        chk({8'h00, v[15:8]}, 16'h0000);
        chk_reg(8'h22, 16'h2345);
        wr(8'hb0, 8'h00);
        chk_reg(8'hb0, 16'h5a3c);
    endtask
    task automatic t_acc_write();
        wr(8'h22, 8'h12);
        repeat (30) @(negedge mclk);
        wr(8'h23, 8'h34);
        chk_reg(8'h22, 16'h2345);
        wr(8'h22, 8'h01);
        wr(8'h23, 8'h00);
        chk({15'h0, meas_offset}, 16'h0001);
        conv(16'h1000);
        chk_reg(8'h22, 16'h0100);
    endtask
    // full offset period: 1023 measurements, then the offset slot
    task automatic t_offset_slot();
        repeat (1022) conv(16'h1000);
        chk({15'h0, meas_offset}, 16'h0000);
        conv(16'h1000);
        chk({15'h0, meas_offset}, 16'h0001);
        chk_reg(8'h22, 16'h04ff);
        ofs_val = 16'sh0010;
        conv(16'h7777);
        chk_reg(8'h20, 16'h1000);
        chk_reg(8'h22, 16'h0500);
        conv(16'h1010);
        chk_reg(8'h20, 16'h1000);
        chk_reg(8'h22, 16'h0501);
        ofs_val = 16'sh0000;
    endtask
    // sums are whole visible steps only when nothing is blanked
    task automatic t_blank();
        setacc(16'h0010);
        conv(16'h0fc1);
        conv(16'h003f);
        chk_reg(8'h22, 16'h0010);
        conv(16'hf03f);
        wr(8'h25, 8'h01);
        conv(16'hfff1);
        chk_reg(8'h22, 16'h0010);
        wr(8'h25, 8'h00);
        conv(16'hfff1);
        chk_reg(8'h22, 16'h000f);
        setacc(16'h0000);
        conv(16'hf000);
        chk_reg(8'h22, 16'h0000);
        setacc(16'hffff);
        conv(16'h7000);
        chk_reg(8'h22, 16'hffff);
    endtask
    task automatic t_bias_gain();
        logic [15:0] v;
        wr(8'h24, 8'h05);
        conv(16'h0100);
        chk_reg(8'h20, 16'h0105);
        rd16(8'h24, v);
        chk({8'h00, v[15:8]}, 16'h0005);
        conv(16'h7fff);
        chk_reg(8'h20, 16'h7fff);
        wr(8'h24, 8'hfb);
        conv(16'h8000);
        chk_reg(8'h20, 16'h8000);
        wr(8'h24, 8'h00);
        temp <= 11'sh190;
        conv(16'h0100);
        chk_reg(8'h20, 16'h0100);
        wr(8'h28, 8'h02);
        wr(8'h29, 8'h00);
        conv(16'h0200);
        chk_reg(8'h20, 16'h0100);
        wr(8'h28, 8'h04);
        // tempco written without a crossing waits for the next one
        wr(8'h2a, 8'h40);
        conv(16'h1000);
        chk_reg(8'h20, 16'h1000);
        temp <= 11'sh1c8;
        conv(16'h1000);
        chk_reg(8'h20, 16'h0f00);
        wr(8'h2a, 8'h00);
        temp <= 11'sh0c8;
    endtask
    // bias alone: 64 steps of 64 make one visible step
    task automatic t_acc_bias();
        setacc(16'h0020);
        wr(8'h26, 8'h40);
        repeat (64) conv(16'h0000);
        chk_reg(8'h22, 16'h0021);
        wr(8'h26, 8'h00);
        repeat (4) conv(16'h0000);
        chk(lbk, 16'h0021);
    endtask
    task automatic t_cycles();
        logic [15:0] v;
        wr(8'h27, 8'hfe);
        rd16(8'h27, v);
        chk({8'h00, v[15:8]}, 16'h00fe);
        repeat (2)
        begin
            @(negedge mclk);
            cycle_tick <= 1'b1;
            @(negedge mclk);
            cycle_tick <= 1'b0;
        end
        block1_locked <= 1'b1;
        wr(8'h27, 8'h10);
        rd16(8'h27, v);
        chk({8'h00, v[15:8]}, 16'h00ff);
    endtask
    // main sequence
    initial
    begin
        rst = 1'b1;
        req = '0;
        temp = 11'sh0c8;
        ee_load = 1'b0;
        ee_img = {11'h400, 16'h5a3c, 8'h00, 8'h00, 16'h2345};
        cycle_tick = 1'b0;
        block1_locked = 1'b0;
        go = 1'b0;
        sense = '0;
        ofs_val = '0;
        errors = 0;
        n_checks = 0;
        cyc = 0;
        nbk = 0;
        repeat (3) @(negedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        ee_load <= 1'b1;
        @(negedge mclk);
        ee_load <= 1'b0;
        t_power_up();
        t_acc_write();
        t_offset_slot();
        t_blank();
        t_bias_gain();
        t_acc_bias();
        t_cycles();
        chk({15'h0, nbk != 0}, 16'h0001);
        stop_test();
    end
endmodule
